// >>> obe_pkg.sv
package obe_pkg;
    // opcode layout of the first word
    localparam int          OPC_HI         = 15;
    localparam int          OPC_LO         = 7;
    localparam logic [8:0]  OPC_BV         = 9'h1E1;
    localparam logic [8:0]  OPC_BNV        = 9'h1EF;
    localparam int          IND_BIT        = 7;
    localparam int          INC_BIT        = 5;
    localparam int          DEC_BIT        = 4;
    localparam int          IDX_BIT        = 6;
    localparam int          NARP_BIT       = 3;
    localparam int          NARP_HI        = 2;
    localparam int          NARP_LO        = 0;
    localparam int          INSN_WORDS     = 2;
    localparam int          CYCLE_CLASS    = 7;
    localparam int          EXEC_CYCLES    = 3;
    localparam logic [15:0] PC_STEP        = 16'h0002;
    localparam logic [15:0] PC_RESET       = 16'h0000;
    localparam logic [15:0] PC_WORD_STEP   = 16'h0001;
    localparam logic [15:0] OPW_RESET      = 16'h0000;
    localparam logic [15:0] AR_ONE         = 16'h0001;
    localparam logic [15:0] AR_RESET       = 16'h0000;
    localparam logic [2:0]  ARP_RESET      = 3'h0;
    localparam logic [1:0]  CNT_ZERO       = 2'h0;
    localparam logic [1:0]  CNT_LAST       = 2'(EXEC_CYCLES - 1);
    typedef enum logic [1:0] {OBE_IDLE, OBE_FETCH2, OBE_WAIT} obe_state_t;
endpackage

// >>> obe_ar_unit.sv
`timescale 1ns/1ps
module obe_ar_unit
    import obe_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        update,
    input  wire logic [7:0]  modField,
    output logic      [15:0] arSel,
    output logic      [2:0]  arpOut,
    output logic      [15:0] ar0Out
);
    logic [15:0] arFile_q [8];
    logic [2:0]  arp_q;
    logic [15:0] cur;
    logic [15:0] step;

    assign cur    = arFile_q[arp_q];
    assign arSel  = cur;
    assign arpOut = arp_q;
    assign ar0Out = arFile_q[0];
    assign step   = modField[IDX_BIT] ? arFile_q[0] : AR_ONE;

    ////////////////////////////////////////////////////////////////////////
    // selected register update
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            for (int i = 0; i < 8; i++) begin
                arFile_q[i] <= AR_RESET;
            end
        end else if (update) begin
            if (modField[INC_BIT] && !modField[DEC_BIT]) begin
                arFile_q[arp_q] <= cur + step;
            end else if (modField[DEC_BIT] && !modField[INC_BIT]) begin
                arFile_q[arp_q] <= cur - step;
            end
        end
    end

    // pointer update
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            arp_q <= ARP_RESET;
        end else if (update && modField[NARP_BIT]) begin
            arp_q <= modField[NARP_HI:NARP_LO];
        end
    end
endmodule

// >>> obe_branch.sv
`timescale 1ns/1ps
// Functional notes
// - overflow set: jump, clear flag; else step two
// - overflow clear: jump; else step two, clear
// - modify auxiliary register and pointer regardless
// - no modification field: registers stay unchanged
// - full 16-bit target; pointer zero to seven
// - two-word instruction, class seven timing
module obe_branch
    import obe_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        instrValid,
    input  wire logic [15:0] instrWord,
    input  wire logic        overflowSet,
    output logic             instrReady,
    output logic      [15:0] progCounter,
    output logic             pcLoad,
    output logic             overflowClear,
    output logic             busy,
    output logic      [15:0] auxRegSel,
    output logic      [2:0]  auxPointer
);
    ////////////////////////////////////////////////////////////////////////
    // sequencer registers
    obe_state_t  state_q;
    logic [15:0] opWord_q;
    logic        isBv_q;
    logic [1:0]  cnt_q;

    // decode wires
    logic [8:0]  opField;
    logic        isBvWord;
    logic        isBnvWord;
    logic        isBr;
    logic        inIdle;
    logic        inFetch2;
    logic        inWait;
    logic        wordTaken;
    logic        otherWord;
    logic        targetTaken;
    logic        waitDone;
    logic        waitNext;
    logic        busyNext;

    // branch outcome wires
    logic        taken;
    logic        clearOv;
    logic [15:0] pcStepped;
    logic [15:0] pcSingle;

    // auxiliary register unit wires
    logic        arUpdate;
    logic [7:0]  modField;
    logic [15:0] arSel;
    logic [2:0]  arpVal;

    ////////////////////////////////////////////////////////////////////////
    // opcode and state decode
    assign opField     = instrWord[OPC_HI:OPC_LO];
    assign isBvWord    = (opField == OPC_BV);
    assign isBnvWord   = (opField == OPC_BNV);
    assign isBr        = isBvWord || isBnvWord;
    assign inIdle      = (state_q == OBE_IDLE);
    assign inFetch2    = (state_q == OBE_FETCH2);
    assign inWait      = (state_q == OBE_WAIT);
    assign wordTaken   = inIdle && instrValid && isBr;
    assign otherWord   = inIdle && instrValid && !isBr;
    assign targetTaken = inFetch2 && instrValid;
    assign waitDone    = inWait && (cnt_q == CNT_LAST - 2'h1);
    assign waitNext    = targetTaken || (inWait && !waitDone);
    assign busyNext    = wordTaken || inFetch2 || waitNext;

    ////////////////////////////////////////////////////////////////////////
    // branch outcome
    assign taken     = isBv_q ? overflowSet : !overflowSet;
    assign clearOv   = overflowSet;
    assign pcStepped = progCounter + PC_STEP;
    assign pcSingle  = progCounter + PC_WORD_STEP;
    assign modField  = opWord_q[IND_BIT:NARP_LO];
    assign arUpdate  = targetTaken && opWord_q[IND_BIT];

    ////////////////////////////////////////////////////////////////////////
    // sequencer state
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q <= OBE_IDLE;
        end else begin
            case (state_q)
                OBE_IDLE: begin
                    if (wordTaken) begin
                        state_q <= OBE_FETCH2;
                    end
                end
                OBE_FETCH2: begin
                    if (targetTaken) begin
                        state_q <= OBE_WAIT;
                    end
                end
                OBE_WAIT: begin
                    if (waitDone) begin
                        state_q <= OBE_IDLE;
                    end
                end
                default: begin
                    state_q <= OBE_IDLE;
                end
            endcase
        end
    end

    // first word capture
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            opWord_q <= OPW_RESET;
        end else if (wordTaken) begin
            opWord_q <= instrWord;
        end
    end

    // branch flavour capture
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            isBv_q <= 1'b0;
        end else if (wordTaken) begin
            isBv_q <= isBvWord;
        end
    end

    // wait state counter
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cnt_q <= CNT_ZERO;
        end else if (targetTaken) begin
            cnt_q <= CNT_ZERO;
        end else if (inWait && !waitDone) begin
            cnt_q <= cnt_q + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // program counter
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            progCounter <= PC_RESET;
        end else if (targetTaken) begin
            if (taken) begin
                progCounter <= instrWord;
            end else begin
                progCounter <= pcStepped;
            end
        end else if (otherWord) begin
            progCounter <= pcSingle;
        end
    end

    // load strobe
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pcLoad <= 1'b0;
        end else begin
            pcLoad <= targetTaken;
        end
    end

    // overflow clear strobe
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            overflowClear <= 1'b0;
        end else begin
            overflowClear <= targetTaken && clearOv;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // handshake from the coming state, so it lags the sequencer only in the first idle cycle after reset
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            instrReady <= 1'b0;
        end else begin
            instrReady <= !waitNext;
        end
    end

    // busy while the coming state is not idle
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            busy <= 1'b0;
        end else begin
            busy <= busyNext;
        end
    end

    // auxiliary mirrors
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            auxRegSel <= AR_RESET;
        end else begin
            auxRegSel <= arSel;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            auxPointer <= ARP_RESET;
        end else begin
            auxPointer <= arpVal;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // auxiliary register unit
    obe_ar_unit u_ar (
        .clk      (clk),
        .reset_n  (reset_n),
        .update   (arUpdate),
        .modField (modField),
        .arSel    (arSel),
        .arpOut   (arpVal),
        .ar0Out   ()
    );
endmodule

// >>> obe_branch_sva.sv
`timescale 1ns/1ps
module obe_branch_chk
    import obe_pkg::*;
(
    input logic        clk,
    input logic        reset_n,
    input logic        instrValid,
    input logic [15:0] instrWord,
    input logic        overflowSet,
    input logic        instrReady,
    input logic        pcLoad,
    input logic        overflowClear,
    input logic        busy,
    input logic [15:0] auxRegSel,
    input logic [2:0]  auxPointer
);
    logic isBr;
    assign isBr = instrValid && instrReady && !busy && instrWord[15:7] inside {OPC_BV, OPC_BNV};
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    chk_clear_pair: assert property (overflowClear |-> pcLoad)
        else $error("lone clear");
    chk_clear_flag: assert property (pcLoad |-> overflowClear == $past(overflowSet))
        else $error("bad clear");
    chk_wait_span: assert property (pcLoad |-> !instrReady [*2] ##1 instrReady)
        else $error("bad wait");
    chk_load_pulse: assert property (pcLoad |=> !pcLoad)
        else $error("long load");
    chk_decode_seq: assert property (isBr ##1 instrValid |=> pcLoad)
        else $error("no load");
    chk_ptr_load: assert property (pcLoad && $past(instrWord[3], 2) |=> auxPointer == $past(instrWord[2:0], 3))
        else $error("bad pointer");
    chk_aux_still: assert property (pcLoad && $past(instrWord[6:0], 2) == 7'h00 |=> $stable(auxPointer) && $stable(auxRegSel))
        else $error("aux moved");
endmodule
bind obe_branch obe_branch_chk chk (.*);

// >>> obe_fetch_mem.sv
`timescale 1ns/1ps
module obe_fetch_mem (
    input  logic        clk,
    input  logic        go,
    input  logic [31:0] words,
    output logic        instrValid = 1'b0,
    output logic [15:0] instrWord = 16'h0000
);
    logic [1:0] cnt_q = 2'h0;
    // first word, then target word on the next cycle
    always @(posedge clk) begin
        cnt_q <= go ? 2'h1 : 2'h0;
        instrValid <= go || cnt_q == 2'h1;
        instrWord <= go ? words[31:16] : cnt_q == 2'h1 ? words[15:0] : ~instrWord;
    end
endmodule

// >>> overflow_branch_execution_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; $display("wrong value %0t output mismatch", $time); end end
module overflow_branch_execution_tb;
    import obe_pkg::*;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        go = 1'b0;
    logic        ovf = 1'b0;
    logic [31:0] words = 32'h0;
    logic        instrValid, instrReady, pcLoad, overflowClear, busy, ov, branch_when_not_overflowed, nb;
    logic [15:0] instrWord, progCounter, auxRegSel, pcExp, tgt, stepExp;
    logic [15:0] arExp [8];
    logic [6:0]  m;
    logic [2:0]  auxPointer, ptrExp;
    logic [16:0] q[$];
    int          err_total = 0;
    int          tests_run = 0;
    int          cyc = 0;
    initial forever #2.5 clk = ~clk;
    obe_fetch_mem mem (.clk(clk), .go(go), .words(words), .instrValid(instrValid), .instrWord(instrWord));
    obe_branch dut (.clk(clk), .reset_n(reset_n), .instrValid(instrValid), .instrWord(instrWord),
        .overflowSet(ovf), .instrReady(instrReady), .progCounter(progCounter), .pcLoad(pcLoad),
        .overflowClear(overflowClear), .busy(busy), .auxRegSel(auxRegSel), .auxPointer(auxPointer));
    task automatic complete_run;
        $display("errors %0d checks %0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(negedge clk) begin
        cyc++;
        if (cyc > 2000) begin
            err_total++;
            complete_run;
        end
        if (pcLoad === 1'b1) begin
            `CHK({progCounter, overflowClear}, q.pop_front())
            `CHK({busy, instrReady}, 2'b10)
        end
    end
    initial begin
        void'($urandom(48));
        pcExp = PC_RESET;
        ptrExp = ARP_RESET;
        for (int k = 0; k < 8; k++) arExp[k] = AR_RESET;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            ov = 1'($urandom);
            branch_when_not_overflowed = 1'($urandom);
            nb = (i % 5 == 4);
            m = (i % 3 == 0) ? 7'h00 : 7'($urandom);
            tgt = (i < 2) ? {16{i[0]}} : 16'($urandom);
            ovf <= ov;
            go <= 1'b1;
            if (nb) begin
                // two plain words, neither one a branch opcode
                words <= {1'b0, 15'($urandom), 1'b0, tgt[14:0]};
                pcExp = pcExp + 16'h0002;
            end else begin
                words <= {branch_when_not_overflowed ? OPC_BNV : OPC_BV, m, tgt};
                pcExp = (branch_when_not_overflowed ^ ov) ? tgt : pcExp + PC_STEP;
                stepExp = m[6] ? arExp[0] : AR_ONE;
                if (m[5] && !m[4]) arExp[ptrExp] = arExp[ptrExp] + stepExp;
                else if (m[4] && !m[5]) arExp[ptrExp] = arExp[ptrExp] - stepExp;
                if (m[3]) ptrExp = m[2:0];
                q.push_back({pcExp, ov});
            end
            @(posedge clk);
            go <= 1'b0;
            repeat (6) @(posedge clk);
            @(negedge clk);
            `CHK(auxPointer, ptrExp)
            `CHK(auxRegSel, arExp[ptrExp])
            `CHK({busy, instrReady}, 2'b01)
        end
        `CHK(q.size(), 0)
        `CHK(progCounter, pcExp)
        complete_run;
    end
endmodule
